// *** hw/smwc_mode_wake.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Latch the wake-up cause on waking from Sleep or Stop for later reads.
// - Any wake from Sleep switches the main regulator back on.
// - Any wake from Stop raises an interrupt to the host.
// - Current level of all four wake inputs is readable over the serial port.
// - Inputs 0 and 1 share one sensitivity setting; inputs 2 and 3 another.
// - Cyclic sense pulses the bias switch periodically and wakes on input change.
// - Direct or cyclic choice applies to all four wake inputs together.
// - Cyclic sense and timed wake exclude each other; enabling the second fails.
// - With timed wake enabled, wake after a fixed time in Sleep or Stop.
// - Wake on CAN activity only when CAN wake is enabled.
// - Transceiver mode is set over the serial port independent of device mode.
// - In Sleep or Stop a rising chip select is a wake-up event.
// - Normal Request starts a 350 ms timer, stopped by a watchdog configuration.
// - Wake from Stop enters Normal Request then gives an unmaskable 10 us pulse.
module smwc_mode_wake #(
  parameter int NREQ_CYC  = smwc_pkg::NREQ_CYC,
  parameter int RST_CYC   = smwc_pkg::RST_CYC,
  parameter int WD_CYC    = smwc_pkg::WD_CYC,
  parameter int CYC_CYC   = smwc_pkg::CYC_CYC,
  parameter int BIAS_CYC  = smwc_pkg::BIAS_CYC,
  parameter int TIMED_CYC = smwc_pkg::TIMED_CYC
) (
  // System clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Serial port pins
  input  wire logic                 spi_clk,
  input  wire logic                 cs_n,
  input  wire logic                 mosi,
  output logic                      miso,
  output logic                      miso_oe,
  // Wake and supervision pins
  input  wire logic [3:0]           wake_lines,
  input  wire logic                 can_activity,
  input  wire logic                 main_regulator_output_overcurrent,
  input  wire logic                 main_regulator_output_undervoltage,
  // Supply, reset and interrupt outputs
  output logic                      main_regulator_output_en_q,
  output logic                      v2_en_q,
  output logic                      hs_switch_q,
  output logic                      rst_out_n_q,
  output logic                      int_n_q,
  output logic                      wd_run_q,
  // Status outputs
  output smwc_pkg::smwc_mode_t      mode_q,
  output smwc_pkg::smwc_wsrc_t      wake_src_q,
  output logic [1:0]                can_mode_q,
  output logic                      debug_q
);
  typedef logic [smwc_pkg::CNT_W-1:0] cnt_t;

  smwc_pkg::smwc_frame_t frame;
  smwc_pkg::smwc_mode_t  state_d;
  smwc_pkg::smwc_wsrc_t  hit;
  logic        frame_tgl;
  logic [2:0]  tg_q;
  logic [2:0]  cs_q;
  logic [3:0]  ln_s1_q, ln_s2_q, ref_q;
  logic [2:0]  pin_s1_q, pin_s2_q;
  logic [3:0]  wake_cfg_q, lpc_q;
  logic        can_wen_q, wd_stop_q, from_sleep_q, pend_stop_q, pend_sleep_q;
  cnt_t        mode_cnt_q, wd_cnt_q, lp_cnt_q;
  logic [smwc_pkg::INT_W-1:0] int_cnt_q;

  smwc_spi_link u_link (
    .spi_clk     (spi_clk),
    .rst_n       (rst_n),
    .cs_n        (cs_n),
    .mosi        (mosi),
    .miso        (miso),
    .miso_oe     (miso_oe),
    .rd_bundle   ({wake_src_q, ln_s2_q}),
    .frame_q     (frame),
    .frame_tgl_q (frame_tgl)
  );

  function automatic logic line_hit(input logic [1:0] sns, input logic lvl,
                                    input logic ref_lvl, input logic cyc,
                                    input logic smp);
    logic chg;
    chg = (sns != smwc_pkg::SNS_OFF) && (lvl != ref_lvl);
    if (cyc) begin
      line_hit = smp && chg;
    end else begin
      line_hit = (sns == smwc_pkg::SNS_HIGH && lvl) ||
                 (sns == smwc_pkg::SNS_LOW && !lvl) ||
                 (sns == smwc_pkg::SNS_ANY && chg);
    end
  endfunction

  // Pin synchronisers; the second stage is read, and also the third for the chip select and frame toggle edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ln_s1_q  <= 4'h0;
      ln_s2_q  <= 4'h0;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      cs_q     <= 3'h7;
      tg_q     <= 3'h0;
    end else begin
      ln_s1_q  <= wake_lines;
      ln_s2_q  <= ln_s1_q;
      pin_s1_q <= {can_activity, main_regulator_output_overcurrent, main_regulator_output_undervoltage};
      pin_s2_q <= pin_s1_q;
      cs_q     <= {cs_q[1:0], cs_n};
      tg_q     <= {tg_q[1:0], frame_tgl};
    end
  end

  wire can_s   = pin_s2_q[2];
  wire ovc_s   = pin_s2_q[1];
  wire uv_s    = pin_s2_q[0];
  wire cs_rise = cs_q[1] & ~cs_q[2];
  wire frm_ev  = tg_q[1] ^ tg_q[2];
  wire wr      = frm_ev & frame.wr;
  wire cfg_ok  = mode_q inside {smwc_pkg::ST_NORMAL, smwc_pkg::ST_STBY,
                                smwc_pkg::ST_NREQ};
  wire w_mode  = wr & (frame.addr == smwc_pkg::ADR_MODE);
  wire w_wdog  = wr & (frame.addr == smwc_pkg::ADR_WDOG);
  wire w_can   = wr & (frame.addr == smwc_pkg::ADR_CAN);
  wire w_lpc   = wr & cfg_ok & (frame.addr == smwc_pkg::ADR_LPC);
  wire w_wake  = wr & cfg_ok & (frame.addr == smwc_pkg::ADR_WAKE);
  wire [2:0] mcode = frame.data[2:0];
  wire m_dbg   = frame.data[smwc_pkg::MC_DEBUG];

  wire in_stop  = mode_q == smwc_pkg::ST_STOP;
  wire in_sleep = mode_q == smwc_pkg::ST_SLEEP;
  wire lp       = in_stop | in_sleep;
  wire run_mode = mode_q inside {smwc_pkg::ST_NORMAL, smwc_pkg::ST_STBY};

  // Cyclic sense needs both bits; all zero leaves the lines direct
  wire cyc_on = lpc_q[smwc_pkg::LPC_BIAS] & lpc_q[smwc_pkg::LPC_AUTO];
  wire fwu_on = lpc_q[smwc_pkg::LPC_TIMED];
  wire wr_cyc = frame.data[smwc_pkg::LPC_BIAS] & frame.data[smwc_pkg::LPC_AUTO];
  // Current setting wins; on a fresh write asking for both, cyclic wins
  wire blk_t  = cyc_on | (wr_cyc & ~fwu_on);
  wire blk_a  = fwu_on & ~cyc_on;
  wire [3:0] lpc_wdata = {frame.data[3:2], frame.data[1] & ~blk_t,
                          frame.data[0] & ~blk_a};

  // Cycle timer shared by cyclic sense and timed wake, never both
  wire cnt_t period = cyc_on ? cnt_t'(CYC_CYC - 1) : cnt_t'(TIMED_CYC - 1);
  wire lp_tick  = lp & (cyc_on | fwu_on);
  wire lp_end   = lp_tick & (lp_cnt_q == period);
  wire bias_win = lp & cyc_on & (lp_cnt_q >= cnt_t'(CYC_CYC - BIAS_CYC));
  wire sample   = bias_win & lp_end;

  // One mode bit for all four lines; pairs share a sensitivity field
  assign hit.lines[0] = lp & line_hit(wake_cfg_q[1:0], ln_s2_q[0], ref_q[0],
                                      cyc_on, sample);
  assign hit.lines[1] = lp & line_hit(wake_cfg_q[1:0], ln_s2_q[1], ref_q[1],
                                      cyc_on, sample);
  assign hit.lines[2] = lp & line_hit(wake_cfg_q[3:2], ln_s2_q[2], ref_q[2],
                                      cyc_on, sample);
  assign hit.lines[3] = lp & line_hit(wake_cfg_q[3:2], ln_s2_q[3], ref_q[3],
                                      cyc_on, sample);
  assign hit.timed = lp & fwu_on & lp_end;
  assign hit.can   = lp & can_wen_q & can_s;
  assign hit.ovc   = in_stop & ovc_s;
  assign hit.spi   = lp & cs_rise;
  wire wake_any = |hit;

  wire wd_to   = wd_run_q & (wd_cnt_q == cnt_t'(WD_CYC - 1));
  wire rst_end = mode_cnt_q == cnt_t'(RST_CYC - 1);
  wire nr_end  = mode_cnt_q == cnt_t'(NREQ_CYC - 1);

  always_comb begin
    state_d = mode_q;
    unique case (mode_q)
      smwc_pkg::ST_RESET: begin
        if (rst_end) state_d = smwc_pkg::ST_NREQ;
      end
      smwc_pkg::ST_NREQ: begin
        if (uv_s) state_d = smwc_pkg::ST_RESET;
        else if (w_wdog) state_d = smwc_pkg::ST_NORMAL;
        else if (nr_end) state_d = from_sleep_q ? smwc_pkg::ST_SLEEP
                                                : smwc_pkg::ST_RESET;
      end
      smwc_pkg::ST_NORMAL, smwc_pkg::ST_STBY: begin
        if (uv_s || wd_to) state_d = smwc_pkg::ST_RESET;
        else if (pend_stop_q && cs_rise) state_d = smwc_pkg::ST_STOP;
        else if (pend_sleep_q && cs_rise) state_d = smwc_pkg::ST_SLEEP;
        else if (w_mode && mcode == smwc_pkg::MC_NORMAL[2:0]) state_d = smwc_pkg::ST_NORMAL;
        else if (w_mode && mcode == smwc_pkg::MC_STANDBY[2:0]) state_d = smwc_pkg::ST_STBY;
      end
      smwc_pkg::ST_STOP: begin
        if (uv_s || wd_to) state_d = smwc_pkg::ST_RESET;
        else if (wake_any) state_d = smwc_pkg::ST_NREQ;
      end
      smwc_pkg::ST_SLEEP: begin
        if (wake_any) state_d = smwc_pkg::ST_RESET;
      end
      default: state_d = smwc_pkg::ST_RESET;
    endcase
  end

  wire chg       = state_d != mode_q;
  wire enter_lp  = !lp && (state_d inside {smwc_pkg::ST_STOP, smwc_pkg::ST_SLEEP});
  wire stop_wake = in_stop && state_d == smwc_pkg::ST_NREQ;
  wire mode_wr   = w_mode & run_mode;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= smwc_pkg::ST_RESET;
      mode_cnt_q <= '0;
      from_sleep_q <= 1'b0;
    end else begin
      mode_q <= state_d;
      mode_cnt_q <= chg ? '0 : mode_cnt_q + cnt_t'(1);
      if (in_sleep && chg) from_sleep_q <= 1'b1;
      else if (mode_q == smwc_pkg::ST_NREQ && state_d == smwc_pkg::ST_NORMAL)
        from_sleep_q <= 1'b0;
    end
  end

  // Low power requests wait for the end of the commanding frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_stop_q  <= 1'b0;
      pend_sleep_q <= 1'b0;
      debug_q      <= 1'b0;
    end else begin
      if (cs_rise || !run_mode) begin
        pend_stop_q  <= 1'b0;
        pend_sleep_q <= 1'b0;
      end else if (mode_wr) begin
        pend_stop_q  <= mcode == smwc_pkg::MC_STOP[2:0];
        pend_sleep_q <= mcode == smwc_pkg::MC_SLEEP[2:0];
      end
      if (w_mode && frame.data == smwc_pkg::MC_OFF) debug_q <= 1'b0;
      else if (w_mode && m_dbg && cfg_ok) debug_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_cfg_q <= 4'h0;
      lpc_q      <= 4'h0;
      can_wen_q  <= 1'b0;
      can_mode_q <= 2'h0;
      wd_stop_q  <= 1'b0;
    end else begin
      if (w_wake) wake_cfg_q <= frame.data;
      if (w_lpc) lpc_q <= lpc_wdata;
      if (w_can) begin
        can_wen_q  <= frame.data[smwc_pkg::CAN_WAKE];
        can_mode_q <= frame.data[1:0];
      end
      if (w_wdog) wd_stop_q <= frame.data[smwc_pkg::WDOG_STOP];
    end
  end

  // Reference levels are taken on entry; cleared causes reload at entry too
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_q      <= 4'h0;
      lp_cnt_q   <= '0;
      wake_src_q <= '0;
    end else begin
      if (enter_lp || sample) ref_q <= ln_s2_q;
      lp_cnt_q <= (!lp_tick || lp_end) ? '0 : lp_cnt_q + cnt_t'(1);
      if (enter_lp) wake_src_q <= '0;
      else if (wake_any) wake_src_q <= wake_src_q | hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q  <= '0;
      int_cnt_q <= '0;
    end else begin
      wd_cnt_q  <= (!wd_run_q || w_wdog || wd_to) ? '0 : wd_cnt_q + cnt_t'(1);
      if (stop_wake)
        int_cnt_q <= smwc_pkg::INT_W'(smwc_pkg::INT_CYC);
      else if (in_sleep)
        int_cnt_q <= '0;
      else if (int_cnt_q != '0)
        int_cnt_q <= int_cnt_q - smwc_pkg::INT_W'(1);
    end
  end

  wire d_run  = state_d inside {smwc_pkg::ST_NORMAL, smwc_pkg::ST_STBY};
  wire d_stop = state_d == smwc_pkg::ST_STOP;
  // Debug also enters Stop without the watchdog
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_regulator_output_en_q   <= 1'b1;
      v2_en_q     <= 1'b0;
      hs_switch_q <= 1'b0;
      rst_out_n_q <= 1'b0;
      int_n_q     <= 1'b1;
      wd_run_q    <= 1'b0;
    end else begin
      main_regulator_output_en_q   <= state_d != smwc_pkg::ST_SLEEP;
      v2_en_q     <= state_d == smwc_pkg::ST_NORMAL;
      hs_switch_q <= lp ? bias_win : d_run & lpc_q[smwc_pkg::LPC_MANUAL];
      rst_out_n_q <= !(state_d inside {smwc_pkg::ST_RESET, smwc_pkg::ST_SLEEP});
      int_n_q     <= (int_cnt_q == '0) || (state_d == smwc_pkg::ST_SLEEP);
      wd_run_q    <= !debug_q && (d_run || (d_stop && wd_stop_q));
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  src_latch_a: assert property (hit.spi |=> wake_src_q.spi) else $error("spi wake not latched");
  sleep_vdd_a: assert property (in_sleep && wake_any |=> main_regulator_output_en_q && mode_q == smwc_pkg::ST_RESET)
    else $error("regulator not back on after sleep wake");
  stop_int_a: assert property (stop_wake |=> mode_q == smwc_pkg::ST_NREQ ##1 (!int_n_q) [*8])
    else $error("stop wake interrupt missing");
  pair_sns_a: assert property (lp && !cyc_on && wake_cfg_q[3:2] == smwc_pkg::SNS_LOW
    && !ln_s2_q[3] |-> hit.lines[3] && (ln_s2_q[2] || hit.lines[2]))
    else $error("pair sensitivity not shared");
  bias_pulse_a: assert property (bias_win && lp_cnt_q == cnt_t'(CYC_CYC - BIAS_CYC) |=> hs_switch_q)
    else $error("bias switch not pulsed");
  excl_a: assert property (cyc_on |-> !fwu_on) else $error("cyclic and timed both on");
  timed_a: assert property (hit.timed && in_stop |=> mode_q == smwc_pkg::ST_NREQ)
    else $error("timed wake missed");
  can_gate_a: assert property (!can_wen_q |-> !hit.can) else $error("can wake while disabled");
  cs_wake_a: assert property (lp && cs_rise |=> !(mode_q inside {smwc_pkg::ST_STOP, smwc_pkg::ST_SLEEP}))
    else $error("chip select wake missed");
  nreq_to_a: assert property (mode_q == smwc_pkg::ST_NREQ && nr_end && !w_wdog && !uv_s
    |=> mode_q inside {smwc_pkg::ST_RESET, smwc_pkg::ST_SLEEP}) else $error("timer expiry ignored");
  sleep_out_a: assert property (in_sleep && $past(in_sleep) |-> !rst_out_n_q && !wd_run_q && int_n_q)
    else $error("sleep outputs wrong");
  dbg_wd_a: assert property (debug_q && $past(debug_q) |-> !wd_run_q) else $error("watchdog runs in debug");
  wd_run_a: assert property (run_mode && d_run && !debug_q |=> wd_run_q)
    else $error("watchdog idle in run mode");

  stop_wake_c: cover property (stop_wake ##1 !int_n_q);
  sleep_cyc_c: cover property (in_sleep && cyc_on && hit.lines[0]);
  nreq_cfg_c:  cover property (mode_q == smwc_pkg::ST_NREQ && w_wdog);
endmodule

// *** hw/smwc_pkg.sv ***
package smwc_pkg;
  localparam int CLK_HZ        = 25_000_000;
  localparam int NREQ_TIME_MS  = 350;
  localparam int NREQ_CYC      = NREQ_TIME_MS * (CLK_HZ / 1000);
  localparam int INT_PULSE_NS  = 10_000;
  localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int INT_CYC       = INT_PULSE_NS / CLK_NS;
  localparam int RST_DUR_US    = 3400;
  localparam int RST_CYC       = RST_DUR_US * (CLK_HZ / 1_000_000);
  localparam int WD_CYC        = NREQ_CYC;
  localparam int CYC_CYC       = 500_000;
  localparam int BIAS_CYC      = 2_500;
  localparam int TIMED_CYC     = 2_500_000;
  localparam int CNT_W         = 24;
  localparam int INT_W         = 9;

  localparam logic [2:0] ADR_MODE = 3'h0;
  localparam logic [2:0] ADR_CAN  = 3'h1;
  localparam logic [2:0] ADR_LPC  = 3'h2;
  localparam logic [2:0] ADR_WAKE = 3'h3;
  localparam logic [2:0] ADR_WDOG = 3'h4;
  localparam logic [2:0] ADR_SRC  = 3'h5;

  localparam logic [3:0] MC_OFF     = 4'h0;
  localparam logic [3:0] MC_NORMAL  = 4'h1;
  localparam logic [3:0] MC_STANDBY = 4'h2;
  localparam logic [3:0] MC_STOP    = 4'h3;
  localparam logic [3:0] MC_SLEEP   = 4'h4;
  localparam int         MC_DEBUG   = 3;

  localparam int LPC_BIAS   = 3;
  localparam int LPC_MANUAL = 2;
  localparam int LPC_TIMED  = 1;
  localparam int LPC_AUTO   = 0;
  localparam int CAN_WAKE   = 3;
  localparam int WDOG_STOP  = 3;

  localparam logic [1:0] SNS_OFF  = 2'h0;
  localparam logic [1:0] SNS_HIGH = 2'h1;
  localparam logic [1:0] SNS_LOW  = 2'h2;
  localparam logic [1:0] SNS_ANY  = 2'h3;

  typedef enum logic [5:0] {
    ST_RESET  = 6'h01,
    ST_NREQ   = 6'h02,
    ST_NORMAL = 6'h04,
    ST_STBY   = 6'h08,
    ST_STOP   = 6'h10,
    ST_SLEEP  = 6'h20
  } smwc_mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic [3:0] data;
  } smwc_frame_t;

  typedef struct packed {
    logic       spi;
    logic       can;
    logic       ovc;
    logic       timed;
    logic [3:0] lines;
  } smwc_wsrc_t;
endpackage

// *** hw/smwc_spi_link.sv ***
`timescale 1ns/1ps
module smwc_spi_link (
  // Link clock and reset
  input  wire logic                  spi_clk,
  input  wire logic                  rst_n,
  // Pins
  input  wire logic                  cs_n,
  input  wire logic                  mosi,
  output logic                       miso,
  output logic                       miso_oe,
  // System side
  input  wire logic [11:0]           rd_bundle,
  output smwc_pkg::smwc_frame_t      frame_q,
  output logic                       frame_tgl_q
);
  logic [2:0]  cnt_q;
  logic [6:0]  sh_q;
  logic [11:0] rd_s1_q;
  logic [11:0] rd_s2_q;
  logic [3:0]  rd_word;
  logic [2:0]  rd_addr;
  logic [2:0]  out_q;
  wire         frame_rst_n = rst_n & ~cs_n;

  // Slow status levels, one flop pair per bit
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_s1_q <= 12'h000;
      rd_s2_q <= 12'h000;
    end else begin
      rd_s1_q <= rd_bundle;
      rd_s2_q <= rd_s1_q;
    end
  end

  assign rd_addr = sh_q[2:0];
  assign rd_word = (rd_addr == smwc_pkg::ADR_WAKE) ? rd_s2_q[3:0] :
                   (rd_addr == smwc_pkg::ADR_SRC)  ? rd_s2_q[7:4] :
                   (rd_addr == smwc_pkg::ADR_CAN)  ? rd_s2_q[11:8] : 4'h0;

  // The link clock stops between frames, so chip select ends the frame
  always_ff @(posedge spi_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_q   <= 3'h0;
      sh_q    <= 7'h00;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
      out_q   <= 3'h0;
    end else begin
      cnt_q   <= cnt_q + 3'h1;
      sh_q    <= {sh_q[5:0], mosi};
      miso_oe <= 1'b1;
      // The address is whole in the shifter only at the fourth edge, so hold the word
      miso    <= (cnt_q == 3'h3) ? rd_word[3] : (cnt_q > 3'h3 && cnt_q < 3'h7) ? out_q[2] : 1'b0;
      out_q   <= (cnt_q == 3'h3) ? rd_word[2:0] : {out_q[1:0], 1'b0};
    end
  end

  // Frame word and toggle change on the same edge; the toggle synchroniser lets the word settle
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q     <= '0;
      frame_tgl_q <= 1'b0;
    end else if (!cs_n && cnt_q == 3'h7) begin
      frame_q     <= {sh_q, mosi};
      frame_tgl_q <= ~frame_tgl_q;
    end
  end
endmodule

// *** verification/smwc_host_model.sv ***
`timescale 1ns/1ps
module smwc_host_model (
  // Serial port
  output logic      spi_clk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  initial begin
    spi_clk = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
  end
  // Link clock stands low outside frames; data idles at the inverse of its last bit
  task automatic xfer(input logic [2:0] a, input logic w, input logic [3:0] d,
                      output logic [3:0] r);
    logic [7:0] f;
    f = {a, w, d};
    r = 4'h0;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = f[i];
      #62.5;
      // Sample before the edge so the design's update on that edge cannot race us
      if (i < 4) r[i] = miso_oe ? miso : 1'bx;
      spi_clk = 1'b1;
      #62.5;
      spi_clk = 1'b0;
    end
    #62.5;
    cs_n = 1'b1;
    mosi = ~mosi;
    #500;
  endtask
endmodule

// *** verification/smwc_mode_wake_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module smwc_mode_wake_tb;
  logic                 clk_sys, rst_n, spi_clk, cs_n, mosi, miso, miso_oe, hs;
  logic [3:0]           wake_lines, rd;
  logic                 can_activity, main_regulator_output_overcurrent, main_regulator_output_undervoltage;
  logic                 main_regulator_output_en_q, v2_en_q, hs_switch_q, rst_out_n_q, int_n_q, wd_run_q;
  logic                 debug_q;
  logic [1:0]           can_mode_q;
  smwc_pkg::smwc_mode_t mode_q;
  smwc_pkg::smwc_wsrc_t wake_src_q;
  int                   miscompares, checked, n;

  smwc_mode_wake #(.NREQ_CYC(200), .RST_CYC(20), .CYC_CYC(64),
    .BIAS_CYC(8), .TIMED_CYC(100)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .wake_lines(wake_lines), .can_activity(can_activity),
    .main_regulator_output_overcurrent(main_regulator_output_overcurrent), .main_regulator_output_undervoltage(main_regulator_output_undervoltage),
    .main_regulator_output_en_q(main_regulator_output_en_q), .v2_en_q(v2_en_q), .hs_switch_q(hs_switch_q),
    .rst_out_n_q(rst_out_n_q), .int_n_q(int_n_q), .wd_run_q(wd_run_q), .mode_q(mode_q),
    .wake_src_q(wake_src_q), .can_mode_q(can_mode_q), .debug_q(debug_q));

  smwc_host_model host (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_mode(input smwc_pkg::smwc_mode_t m, input int lim);
    n = 0;
    while (mode_q !== m && n < lim) begin
      step(1);
      n++;
    end
    if (mode_q !== m) begin
      `CHK(mode_q, m);
      test_done();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    host.xfer(a, 1'b1, d, rd);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [3:0] e);
    host.xfer(a, 1'b0, 4'h0, rd);
    `CHK(rd, e);
  endtask
  task automatic to_normal();
    wr(smwc_pkg::ADR_WDOG, 4'h0);
    wait_mode(smwc_pkg::ST_NORMAL, 20);
  endtask
  task automatic stop_now();
    wr(smwc_pkg::ADR_MODE, smwc_pkg::MC_STOP);
    wait_mode(smwc_pkg::ST_STOP, 20);
  endtask
  task automatic hs_seen(input int k);
    hs = 1'b0;
    repeat (k) begin
      step(1);
      if (hs_switch_q === 1'b1) hs = 1'b1;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    wake_lines = 4'h0;
    can_activity = 1'b0;
    main_regulator_output_overcurrent = 1'b0;
    main_regulator_output_undervoltage = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_mode(smwc_pkg::ST_NREQ, 100);
    `CHK({main_regulator_output_en_q, v2_en_q, rst_out_n_q}, 3'b101);
    to_normal();
    `CHK(wd_run_q, 1'b1);
    wr(smwc_pkg::ADR_MODE, 4'h9);
    `CHK({debug_q, wd_run_q, mode_q}, {2'b10, smwc_pkg::ST_NORMAL});
    @(posedge clk_sys) main_regulator_output_undervoltage <= 1'b1;
    wait_mode(smwc_pkg::ST_RESET, 10);
    `CHK(rst_out_n_q, 1'b0);
    @(posedge clk_sys) main_regulator_output_undervoltage <= 1'b0;
    wait_mode(smwc_pkg::ST_NREQ, 60);
    to_normal();
    wr(smwc_pkg::ADR_MODE, smwc_pkg::MC_OFF);
    step(2);
    `CHK({debug_q, wd_run_q}, 2'b01);
    @(posedge clk_sys) wake_lines <= 4'hA;
    rd_chk(smwc_pkg::ADR_WAKE, 4'hA);
    // Lines 2 and 3 stay high so low-level entry does not wake at once
    @(posedge clk_sys) wake_lines <= 4'hC;
    wr(smwc_pkg::ADR_CAN, 4'h2);
    step(4);
    `CHK({mode_q, can_mode_q}, {smwc_pkg::ST_NORMAL, 2'h2});
    // Pair 0 high-level, pair 1 low-level, direct wake
    wr(smwc_pkg::ADR_WAKE, 4'h9);
    wr(smwc_pkg::ADR_LPC, 4'h0);
    stop_now();
    step(30);
    `CHK(mode_q, smwc_pkg::ST_STOP);
    @(posedge clk_sys) wake_lines <= 4'h4;
    wait_mode(smwc_pkg::ST_NREQ, 20);
    step(2);
    `CHK({int_n_q, wake_src_q}, 9'h008);
    rd_chk(smwc_pkg::ADR_SRC, 4'h8);
    to_normal();
    wr(smwc_pkg::ADR_WAKE, 4'h0);
    stop_now();
    @(posedge clk_sys) can_activity <= 1'b1;
    step(30);
    `CHK(mode_q, smwc_pkg::ST_STOP);
    rd_chk(smwc_pkg::ADR_CAN, 4'h0);
    wait_mode(smwc_pkg::ST_NREQ, 20);
    `CHK(wake_src_q, 8'h80);
    @(posedge clk_sys) can_activity <= 1'b0;
    wr(smwc_pkg::ADR_CAN, 4'hA);
    to_normal();
    stop_now();
    @(posedge clk_sys) can_activity <= 1'b1;
    wait_mode(smwc_pkg::ST_NREQ, 20);
    `CHK({wake_src_q, can_mode_q}, 10'h102);
    @(posedge clk_sys) can_activity <= 1'b0;
    to_normal();
    stop_now();
    @(posedge clk_sys) main_regulator_output_overcurrent <= 1'b1;
    wait_mode(smwc_pkg::ST_NREQ, 20);
    `CHK(wake_src_q, 8'h20);
    @(posedge clk_sys) main_regulator_output_overcurrent <= 1'b0;
    to_normal();
    wr(smwc_pkg::ADR_LPC, 4'h2);
    wr(smwc_pkg::ADR_MODE, smwc_pkg::MC_SLEEP);
    wait_mode(smwc_pkg::ST_SLEEP, 20);
    step(2);
    `CHK({main_regulator_output_en_q, rst_out_n_q, int_n_q, wd_run_q}, 4'b0010);
    wait_mode(smwc_pkg::ST_RESET, 200);
    step(2);
    `CHK({main_regulator_output_en_q, wake_src_q}, 9'h110);
    wait_mode(smwc_pkg::ST_NREQ, 60);
    to_normal();
    // Timed wake holds; a cyclic request on top of it is ignored
    wr(smwc_pkg::ADR_LPC, 4'h2);
    wr(smwc_pkg::ADR_LPC, 4'hB);
    stop_now();
    hs_seen(80);
    `CHK(hs, 1'b0);
    wait_mode(smwc_pkg::ST_NREQ, 60);
    `CHK(wake_src_q, 8'h10);
    to_normal();
    wr(smwc_pkg::ADR_LPC, 4'h0);
    wr(smwc_pkg::ADR_LPC, 4'h9);
    wr(smwc_pkg::ADR_WAKE, 4'h3);
    stop_now();
    hs_seen(70);
    `CHK(hs, 1'b1);
    @(posedge clk_sys) wake_lines <= 4'h5;
    wait_mode(smwc_pkg::ST_NREQ, 150);
    `CHK(wake_src_q, 8'h01);
    test_done();
  end
endmodule
